/* File: src/icl_pkg.sv */
// icl_pkg: constants, enumerations and carriers of the config and cal lock
package icl_pkg;

////////////////////////////////////////////////////////////////////////////////
// register map (byte addresses on the wishbone slave)
localparam logic [7:0] ADR_CFG     = 8'h00;
localparam logic [7:0] ADR_LANG    = 8'h04;
localparam logic [7:0] ADR_STAT    = 8'h08;
localparam logic [7:0] ADR_CODE0   = 8'h0c;
localparam logic [7:0] ADR_CODE1   = 8'h10;
localparam logic [7:0] ADR_CODE2   = 8'h14;
localparam logic [7:0] ADR_CLEN    = 8'h18;
localparam logic [7:0] ADR_LOCK    = 8'h1c;
localparam logic [7:0] ADR_NEWCODE = 8'h20;
localparam logic [7:0] ADR_CALCNT  = 8'h24;

// field positions
localparam int CFG_PORT_BIT  = 0;
localparam int CFG_BAUD_LSB  = 1;
localparam int CFG_PAR_LSB   = 4;
localparam int CFG_LANG_LSB  = 6;
localparam int CFG_ADDR_LSB  = 8;
localparam int CFG_DBITS_LSB = 16;
localparam int STAT_LOCK_BIT = 0;
localparam int STAT_ERR_BIT  = 1;
localparam int STAT_TALK_BIT = 2;
localparam int STAT_JMP_BIT  = 3;

////////////////////////////////////////////////////////////////////////////////
// widths and counts
localparam int CODE_CHARS = 12;
localparam int KEY_DIGITS = 6;
localparam int KEY_LEN    = 8;
localparam int CAL_CNT_W  = 15;

typedef enum logic [0:0] {PORT_GPIB = 1'b0, PORT_SERIAL = 1'b1} icl_port_t;
typedef enum logic [2:0] {
	BAUD_300 = 3'h0, BAUD_600 = 3'h1, BAUD_1200 = 3'h2,
	BAUD_2400 = 3'h3, BAUD_4800 = 3'h4, BAUD_9600 = 3'h5
} icl_baud_t;
typedef enum logic [1:0] {
	PAR_NONE = 2'h0, PAR_EVEN = 2'h1, PAR_ODD = 2'h2
} icl_parity_t;
typedef enum logic [1:0] {
	LANG_SCPI = 2'h0, LANG_LEG_A = 2'h1, LANG_LEG_B = 2'h2
} icl_lang_t;
typedef enum logic [2:0] {
	KP_NONE = 3'h0, KP_PORT = 3'h1, KP_BAUD = 3'h2, KP_PARITY = 3'h3,
	KP_LANG = 3'h4, KP_ADDR = 3'h5, KP_SECURE = 3'h6, KP_NEWCODE = 3'h7
} icl_kp_op_t;

// keypad request: digits[0] is the first digit keyed
typedef struct packed {
	logic                       valid;
	icl_kp_op_t                 op;
	logic [7:0]                 value;
	logic [KEY_DIGITS-1:0][7:0] digits;
} icl_kp_req_t;

// persistent image; code[0] is the first character
typedef struct packed {
	icl_port_t                  port;
	icl_baud_t                  baud;
	icl_parity_t                parity;
	icl_lang_t                  lang;
	logic [4:0]                 addr;
	logic                       locked;
	logic [3:0]                 code_len;
	logic [CODE_CHARS-1:0][7:0] code;
	logic [CAL_CNT_W-1:0]       cal_count;
} icl_nv_t;

////////////////////////////////////////////////////////////////////////////////
// values
localparam logic [4:0] DEF_ADDR       = 5'h16;
localparam logic [4:0] TALK_ONLY_ADDR = 5'h1f;
localparam logic [3:0] DBITS_NONE     = 4'h8;
localparam logic [3:0] DBITS_PARITY   = 4'h7;
// arbitrary key prefix and factory code, low byte is the first character
localparam logic [15:0] KEY_PREFIX   = 16'h515a;
localparam logic [95:0] FACTORY_CODE = 96'h0000_0000_3635_3433_3231_515a;
localparam logic [3:0]  FACTORY_LEN  = 4'h8;
localparam icl_nv_t NV_FACTORY = '{
	port: PORT_GPIB, baud: BAUD_9600, parity: PAR_EVEN, lang: LANG_SCPI,
	addr: DEF_ADDR, locked: 1'b1, code_len: FACTORY_LEN,
	code: FACTORY_CODE, cal_count: 15'h0000};

endpackage : icl_pkg

/* File: src/icl_cfg_lock.sv */
// icl_cfg_lock: remote port config, language guard and calibration lock
`timescale 1ns/1ps

// Overview of operation
// - exactly one remote port enabled; parallel bus port is the default
// - port, baud and parity change from keypad only, never remotely
// - all settings, code and count live in the persistent image
// - at power-up show bus address, or the serial text when serial
// - serial port with talk-only address sends readings in local mode
// - baud is one of six rates, default 9600
// - no parity means eight data bits, even or odd mean seven
// - default framing is even parity, seven data bits
// - three languages, SCPI default
// - serial port allows SCPI only, except a bus language write in the cycle the keypad selects serial
// - three short remote commands pick the language
// - locked as shipped; calibrate hidden and refused while locked
// - remote code: one to twelve alphanumerics, first a letter
// - keypad code: prefix plus six digits, keypad checks the digits
// - lock state changes only with the matching stored code
// - new code accepted only while unlocked, shared by keypad and bus
// - jumper bypasses the lock check for a code change
// - calibration counter adds one per point, wraps 32767 to 0
// - counter readable remotely and on keypad, never writable
// - factory code held until replaced
module icl_cfg_lock
	import icl_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [7:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	input  icl_kp_req_t      KP_REQ,
	output logic             KP_DONE,
	output logic             KP_REJECT,
	input  icl_nv_t          NV_IMAGE_IN,
	output icl_nv_t          NV_IMAGE_OUT,
	output logic             NV_WRITE,
	input  wire logic        FACTORY_LOAD,
	input  wire logic        JUMPER_BYPASS,
	input  wire logic        LOCAL_MODE,
	input  wire logic        CAL_POINT_STORED,
	output logic             GPIB_EN,
	output logic             SERIAL_EN,
	output icl_baud_t        BAUD_SEL,
	output icl_parity_t      PARITY_SEL,
	output logic      [3:0]  DATA_BITS,
	output icl_lang_t        LANG_SEL,
	output logic      [4:0]  BUS_ADDR,
	output logic             TALK_ONLY_SERIAL,
	output logic             CAL_LOCKED,
	output logic             CAL_MENU_SHOW,
	output logic      [14:0] CAL_COUNT,
	output logic             SHOW_BUS_ADDR,
	output logic             SHOW_SERIAL_TEXT
);

////////////////////////////////////////////////////////////////////////////////
// state
icl_nv_t                    nv_q, nv_d;
logic [CODE_CHARS-1:0][7:0] stg_code_q;
logic [3:0]                 stg_len_q;
logic                       ack_q;
logic [31:0]                dat_q;
logic                       err_q;
logic                       nvw_q;
logic                       show_q;
logic                       kp_done_q, kp_rej_q;
logic                       err_set, kp_ok, kp_bad;

////////////////////////////////////////////////////////////////////////////////
// bus decode
wire bus_req  = WB_CYC_I & WB_STB_I & ~ack_q;
wire bus_wr   = bus_req & WB_WE_I;
wire lane0    = WB_SEL_I[0];
wire hit_cfg  = WB_ADR_I == ADR_CFG;
wire hit_lang = WB_ADR_I == ADR_LANG;
wire hit_stat = WB_ADR_I == ADR_STAT;
wire hit_c0   = WB_ADR_I == ADR_CODE0;
wire hit_c1   = WB_ADR_I == ADR_CODE1;
wire hit_c2   = WB_ADR_I == ADR_CODE2;
wire hit_clen = WB_ADR_I == ADR_CLEN;
wire hit_lock = WB_ADR_I == ADR_LOCK;
wire hit_newc = WB_ADR_I == ADR_NEWCODE;
wire hit_cnt  = WB_ADR_I == ADR_CALCNT;

wire wr_lang = bus_wr & hit_lang & lane0;
wire wr_lock = bus_wr & hit_lock & lane0;
wire wr_newc = bus_wr & hit_newc & lane0;
wire wr_stat = bus_wr & hit_stat & lane0;
wire wr_clen = bus_wr & hit_clen & lane0;

wire serial_on = nv_q.port == PORT_SERIAL;
wire [3:0] dbits = (nv_q.parity == PAR_NONE) ? DBITS_NONE
	: DBITS_PARITY;

// cfg is read-only: remote writes to port, baud and parity fall away
wire [31:0] cfg_word = {12'h000, dbits, 3'h0, nv_q.addr,
	nv_q.lang, nv_q.parity, nv_q.baud, nv_q.port};
wire [31:0] stat_word = {28'h0000000, JUMPER_BYPASS, TALK_ONLY_SERIAL,
	err_q, nv_q.locked};
wire [31:0] rd_word =
	hit_cfg  ? cfg_word :
	hit_lang ? {30'h00000000, nv_q.lang} :
	hit_stat ? stat_word :
	hit_c0   ? stg_code_q[3:0] :
	hit_c1   ? stg_code_q[7:4] :
	hit_c2   ? stg_code_q[11:8] :
	hit_clen ? {28'h0000000, stg_len_q} :
	hit_lock ? {31'h00000000, nv_q.locked} :
	hit_cnt  ? {17'h00000, nv_q.cal_count} :
	32'h00000000;

////////////////////////////////////////////////////////////////////////////////
// code checks, one slice per character
logic [CODE_CHARS-1:0] eq_v, fmt_v;
logic [KEY_DIGITS-1:0] key_eq_v, key_dig_v;

genvar gi;
generate
	for (gi = 0; gi < CODE_CHARS; gi++) begin : g_chr
		wire [7:0] c     = stg_code_q[gi];
		wire       in_s  = 4'(gi) < stg_len_q;
		wire       is_lt = (c >= 8'h41 && c <= 8'h5a) ||
			(c >= 8'h61 && c <= 8'h7a);
		wire       is_dg = c >= 8'h30 && c <= 8'h39;
		assign eq_v[gi]  = ~in_s | (c == nv_q.code[gi]);
		assign fmt_v[gi] = ~in_s | is_lt | ((gi != 0) & is_dg);
	end
	for (gi = 0; gi < KEY_DIGITS; gi++) begin : g_key
		wire [7:0] k = KP_REQ.digits[gi];
		assign key_eq_v[gi]  = k == nv_q.code[gi+2];
		assign key_dig_v[gi] = k >= 8'h30 && k <= 8'h39;
	end
endgenerate

wire remote_match = (&eq_v) && (stg_len_q == nv_q.code_len);
wire remote_fmt   = (&fmt_v) && (stg_len_q != 4'h0) &&
	(stg_len_q <= 4'(CODE_CHARS));
wire key_form     = (nv_q.code_len == 4'(KEY_LEN)) &&
	({nv_q.code[1], nv_q.code[0]} == KEY_PREFIX);
wire key_match    = key_form && (&key_eq_v);
// new code may be stored when unlocked, or anytime with the jumper fitted
wire code_open    = ~nv_q.locked | JUMPER_BYPASS;

////////////////////////////////////////////////////////////////////////////////
// next persistent state; keypad first, then bus, so a bus command in the
// same cycle overrides the keypad edit, while its checks still see nv_q
always_comb begin
	icl_lang_t rl;
	rl      = icl_lang_t'(WB_DAT_I[1:0]);
	nv_d    = nv_q;
	err_set = 1'b0;
	kp_ok   = 1'b0;
	kp_bad  = 1'b0;
	if (KP_REQ.valid) begin
		kp_ok = 1'b1;
		case (KP_REQ.op)
			KP_PORT: begin
				nv_d.port = icl_port_t'(KP_REQ.value[0]);
				// a legacy language cannot survive a move to serial
				if (KP_REQ.value[0])
					nv_d.lang = LANG_SCPI;
			end
			KP_BAUD: begin
				if (KP_REQ.value <= 8'(BAUD_9600))
					nv_d.baud = icl_baud_t'(KP_REQ.value[2:0]);
				else
					kp_bad = 1'b1;
			end
			KP_PARITY: begin
				if (KP_REQ.value <= 8'(PAR_ODD))
					nv_d.parity = icl_parity_t'(KP_REQ.value[1:0]);
				else
					kp_bad = 1'b1;
			end
			KP_LANG: begin
				if (KP_REQ.value > 8'(LANG_LEG_B) ||
					(serial_on && KP_REQ.value != 8'(LANG_SCPI)))
					kp_bad = 1'b1;
				else
					nv_d.lang = icl_lang_t'(KP_REQ.value[1:0]);
			end
			KP_ADDR: begin
				nv_d.addr = KP_REQ.value[4:0];
			end
			KP_SECURE: begin
				if (key_match)
					nv_d.locked = KP_REQ.value[0];
				else
					kp_bad = 1'b1;
			end
			KP_NEWCODE: begin
				if (code_open && (&key_dig_v)) begin
					nv_d.code_len = 4'(KEY_LEN);
					nv_d.code     = '0;
					{nv_d.code[1], nv_d.code[0]} = KEY_PREFIX;
					for (int j = 0; j < KEY_DIGITS; j++)
						nv_d.code[j+2] = KP_REQ.digits[j];
				end else begin
					kp_bad = 1'b1;
				end
			end
			default: begin
				kp_bad = 1'b1;
			end
		endcase
		if (kp_bad)
			kp_ok = 1'b0;
	end
	if (wr_lang) begin
		// value 0, 1, 2 is the scpi, legacy a, legacy b short command
		if (WB_DAT_I[7:2] != 6'h00 || rl == 2'h3 ||
			(serial_on && rl != LANG_SCPI))
			err_set = 1'b1;
		else
			nv_d.lang = rl;
	end
	if (wr_lock) begin
		if (remote_match)
			nv_d.locked = WB_DAT_I[0];
		else
			err_set = 1'b1;
	end
	if (wr_newc) begin
		if (code_open && remote_fmt) begin
			nv_d.code_len = stg_len_q;
			for (int j = 0; j < CODE_CHARS; j++)
				nv_d.code[j] = (4'(j) < stg_len_q) ? stg_code_q[j] : 8'h00;
		end else begin
			err_set = 1'b1;
		end
	end
	// calibration points only land while unlocked; counter wraps by width
	if (CAL_POINT_STORED && !nv_q.locked)
		nv_d.cal_count = nv_q.cal_count + 15'h0001;
	if (FACTORY_LOAD)
		nv_d = NV_FACTORY;
end

////////////////////////////////////////////////////////////////////////////////
// registers
always_ff @(posedge CLK) begin
	if (RST) begin
		// reset reloads the stored image rather than defaults
		nv_q <= NV_IMAGE_IN;
	end else begin
		nv_q <= nv_d;
	end
end

always_ff @(posedge CLK) begin
	if (RST)
		nvw_q <= 1'b0;
	else
		nvw_q <= nv_d != nv_q;
end

always_ff @(posedge CLK) begin
	if (RST) begin
		ack_q <= 1'b0;
		dat_q <= 32'h00000000;
	end else begin
		ack_q <= bus_req;
		if (bus_req && !WB_WE_I)
			dat_q <= rd_word;
	end
end

always_ff @(posedge CLK) begin
	if (RST) begin
		stg_code_q <= '0;
		stg_len_q  <= 4'h0;
	end else begin
		for (int b = 0; b < 4; b++) begin
			if (bus_wr && WB_SEL_I[b]) begin
				if (hit_c0)
					stg_code_q[b]   <= WB_DAT_I[8*b +: 8];
				if (hit_c1)
					stg_code_q[b+4] <= WB_DAT_I[8*b +: 8];
				if (hit_c2)
					stg_code_q[b+8] <= WB_DAT_I[8*b +: 8];
			end
		end
		if (wr_clen)
			stg_len_q <= WB_DAT_I[3:0];
	end
end

// error flag: a new rejection wins over a clear in the same cycle
always_ff @(posedge CLK) begin
	if (RST)
		err_q <= 1'b0;
	else
		err_q <= (err_q & ~(wr_stat & WB_DAT_I[STAT_ERR_BIT])) | err_set;
end

always_ff @(posedge CLK) begin
	if (RST) begin
		show_q    <= 1'b1;
		kp_done_q <= 1'b0;
		kp_rej_q  <= 1'b0;
	end else begin
		if (KP_REQ.valid)
			show_q <= 1'b0;
		kp_done_q <= kp_ok;
		kp_rej_q  <= kp_bad;
	end
end

////////////////////////////////////////////////////////////////////////////////
// outputs
assign WB_ACK_O         = ack_q;
assign WB_DAT_O         = dat_q;
assign KP_DONE          = kp_done_q;
assign KP_REJECT        = kp_rej_q;
assign NV_IMAGE_OUT     = nv_q;
assign NV_WRITE         = nvw_q;
assign GPIB_EN          = ~serial_on;
assign SERIAL_EN        = serial_on;
assign BAUD_SEL         = nv_q.baud;
assign PARITY_SEL       = nv_q.parity;
assign DATA_BITS        = dbits;
assign LANG_SEL         = nv_q.lang;
assign BUS_ADDR         = nv_q.addr;
assign TALK_ONLY_SERIAL = serial_on && (nv_q.addr == TALK_ONLY_ADDR) &&
	LOCAL_MODE;
assign CAL_LOCKED       = nv_q.locked;
assign CAL_MENU_SHOW    = ~nv_q.locked;
assign CAL_COUNT        = nv_q.cal_count;
assign SHOW_BUS_ADDR    = show_q & ~serial_on;
assign SHOW_SERIAL_TEXT = show_q & serial_on;

endmodule : icl_cfg_lock

/* File: testbench/icl_host.sv */
// icl_host: wishbone host model standing in for the remote controller
`timescale 1ns/1ps
module icl_host (
	input  wire logic        clk,
	input  wire logic        ack,
	input  wire logic [31:0] dat_i,
	output logic             cyc,
	output logic             we,
	output logic [7:0]       adr,
	output logic [31:0]      dat_o
);
	initial begin
		cyc = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		dat_o = 32'h0;
	end

	// one classic cycle; the host never assumes a latency
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat_o <= d;
		do @(posedge clk); while (ack !== 1'b1);
		q = dat_i;
		cyc <= 1'b0;
		// released data lines must not keep showing the last value
		dat_o <= ~d;
		#1;
	endtask : xfer
endmodule : icl_host

/* File: testbench/icl_cfg_lock_assertions.sv */
// icl_cfg_lock_assertions: port-level property checker
`timescale 1ns/1ps
module icl_cfg_lock_chk
	import icl_pkg::*;
(
	input wire logic        CLK,
	input wire logic        RST,
	input wire logic        WB_CYC_I,
	input wire logic        WB_STB_I,
	input wire logic        WB_WE_I,
	input wire logic        WB_ACK_O,
	input icl_kp_req_t      KP_REQ,
	input wire logic        FACTORY_LOAD,
	input wire logic        LOCAL_MODE,
	input wire logic        CAL_POINT_STORED,
	input wire logic        GPIB_EN,
	input wire logic        SERIAL_EN,
	input icl_baud_t        BAUD_SEL,
	input icl_parity_t      PARITY_SEL,
	input wire logic [3:0]  DATA_BITS,
	input icl_lang_t        LANG_SEL,
	input wire logic [4:0]  BUS_ADDR,
	input wire logic        TALK_ONLY_SERIAL,
	input wire logic        CAL_LOCKED,
	input wire logic        CAL_MENU_SHOW,
	input wire logic [14:0] CAL_COUNT
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	wire bus_req = WB_CYC_I & WB_STB_I;
	// no keypad, bus write or factory load: nothing may move the lock
	wire quiet = !KP_REQ.valid && !(bus_req && WB_WE_I) && !FACTORY_LOAD;

	//////////////////////////////////////////////////////////////////////////
	property p_one_port; GPIB_EN != SERIAL_EN; endproperty
	a_one_port: assert property (p_one_port)
		else $error("port enables not exclusive");
	property p_dbits;
		DATA_BITS == ((PARITY_SEL == PAR_NONE) ? DBITS_NONE : DBITS_PARITY);
	endproperty
	a_dbits: assert property (p_dbits)
		else $error("data bits do not follow parity");
	property p_talk;
		TALK_ONLY_SERIAL ==
			(SERIAL_EN && BUS_ADDR == TALK_ONLY_ADDR && LOCAL_MODE);
	endproperty
	a_talk: assert property (p_talk)
		else $error("talk only output wrong");
	property p_ser_scpi; SERIAL_EN |-> LANG_SEL == LANG_SCPI; endproperty
	a_ser_scpi: assert property (p_ser_scpi)
		else $error("legacy language on serial port");
	property p_menu; CAL_MENU_SHOW == !CAL_LOCKED; endproperty
	a_menu: assert property (p_menu)
		else $error("calibrate menu shown while locked");
	property p_ack; bus_req && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O; endproperty
	a_ack: assert property (p_ack)
		else $error("bus answer not a one cycle pulse");
	property p_remote_cfg;
		!KP_REQ.valid && !FACTORY_LOAD |=>
			$stable({GPIB_EN, BAUD_SEL, PARITY_SEL});
	endproperty
	a_remote_cfg: assert property (p_remote_cfg)
		else $error("port or framing changed without keypad");
	property p_count;
		CAL_POINT_STORED && !CAL_LOCKED && !FACTORY_LOAD |=>
			CAL_COUNT == $past(CAL_COUNT) + 15'h0001;
	endproperty
	a_count: assert property (p_count)
		else $error("calibration count did not step");
	property p_lock_hold; quiet |=> $stable(CAL_LOCKED); endproperty
	a_lock_hold: assert property (p_lock_hold)
		else $error("lock state moved without a request");
	property p_no_count; CAL_POINT_STORED && CAL_LOCKED && quiet |=>
		$stable(CAL_COUNT); endproperty
	a_no_count: assert property (p_no_count)
		else $error("count moved while locked");
	c_unlock: cover property ($fell(CAL_LOCKED));
	c_wrap: cover property (CAL_COUNT == 15'h7fff ##1 CAL_COUNT == 15'h0000);
	c_legacy: cover property (LANG_SEL == LANG_LEG_B);
endmodule : icl_cfg_lock_chk

bind icl_cfg_lock icl_cfg_lock_chk i_chk (
	.CLK             (CLK),
	.RST             (RST),
	.WB_CYC_I        (WB_CYC_I),
	.WB_STB_I        (WB_STB_I),
	.WB_WE_I         (WB_WE_I),
	.WB_ACK_O        (WB_ACK_O),
	.KP_REQ          (KP_REQ),
	.FACTORY_LOAD    (FACTORY_LOAD),
	.LOCAL_MODE      (LOCAL_MODE),
	.CAL_POINT_STORED(CAL_POINT_STORED),
	.GPIB_EN         (GPIB_EN),
	.SERIAL_EN       (SERIAL_EN),
	.BAUD_SEL        (BAUD_SEL),
	.PARITY_SEL      (PARITY_SEL),
	.DATA_BITS       (DATA_BITS),
	.LANG_SEL        (LANG_SEL),
	.BUS_ADDR        (BUS_ADDR),
	.TALK_ONLY_SERIAL(TALK_ONLY_SERIAL),
	.CAL_LOCKED      (CAL_LOCKED),
	.CAL_MENU_SHOW   (CAL_MENU_SHOW),
	.CAL_COUNT       (CAL_COUNT)
);

/* File: testbench/icl_cfg_lock_tb.sv */
// icl_cfg_lock_tb: self-checking bench for the config and cal lock
`timescale 1ns/1ps
module icl_cfg_lock_tb
	import icl_pkg::*;
;
	logic        clk, rst, fac, jmp, loc, cpt, kdone, krej, ack, cyc, we;
	logic        gpib, ser, talk, lck, menu, sh_a, sh_s, nvw;
	logic [7:0]  adr;
	logic [31:0] wdat, rdat, r;
	logic [3:0]  dbits;
	logic [4:0]  baddr;
	logic [14:0] cnt;
	icl_baud_t   baud;
	icl_parity_t par;
	icl_lang_t   lang;
	icl_kp_req_t kp;
	icl_nv_t     nv_in, img, nv_out;
	int          fail_count = 0;
	int          cmp_count = 0;
	wire [16:0]  st = {gpib, ser, baud, par, dbits, lang, lck, menu, sh_a, sh_s};
	localparam logic [16:0] PWR = {2'b10, BAUD_9600, PAR_EVEN, DBITS_PARITY,
		LANG_SCPI, 4'b1010};
	localparam logic [31:0] CFG0 = {12'h0, DBITS_PARITY, 3'h0, DEF_ADDR,
		LANG_SCPI, PAR_EVEN, BAUD_9600, PORT_GPIB};

	icl_cfg_lock i_dut (.CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(cyc),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat),
		.WB_DAT_O(rdat), .WB_ACK_O(ack), .KP_REQ(kp), .KP_DONE(kdone),
		.KP_REJECT(krej), .NV_IMAGE_IN(nv_in), .NV_IMAGE_OUT(nv_out),
		.NV_WRITE(nvw),
		.FACTORY_LOAD(fac), .JUMPER_BYPASS(jmp), .LOCAL_MODE(loc),
		.CAL_POINT_STORED(cpt), .GPIB_EN(gpib), .SERIAL_EN(ser),
		.BAUD_SEL(baud), .PARITY_SEL(par), .DATA_BITS(dbits), .LANG_SEL(lang),
		.BUS_ADDR(baddr), .TALK_ONLY_SERIAL(talk), .CAL_LOCKED(lck),
		.CAL_MENU_SHOW(menu), .CAL_COUNT(cnt), .SHOW_BUS_ADDR(sh_a),
		.SHOW_SERIAL_TEXT(sh_s));
	icl_host i_host (.clk(clk), .ack(ack), .dat_i(rdat), .cyc(cyc), .we(we),
		.adr(adr), .dat_o(wdat));

	always #20 clk = ~clk;

	//////////////////////////////////////////////////////////////////////////
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(logic [7:0] a, logic [31:0] d);
		i_host.xfer(1'b1, a, d, r);
	endtask : wr
	task automatic rd(logic [7:0] a, logic [31:0] e, string n);
		i_host.xfer(1'b0, a, 32'h0, r);
		chk(n, e, r);
	endtask : rd
	task automatic key(icl_kp_op_t op, logic [7:0] v, logic [47:0] d,
		logic ok);
		@(posedge clk);
		kp <= '{1'b1, op, v, d};
		@(posedge clk);
		kp.valid <= 1'b0;
		#1 chk("kp_answer", ok ? 32'h1 : 32'h2, {30'h0, krej, kdone});
	endtask : key
	task automatic reset_dut(icl_nv_t im);
		@(posedge clk);
		rst <= 1'b1;
		nv_in <= im;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		#1;
	endtask : reset_dut
	task automatic stage(logic [95:0] c, logic [3:0] n);
		wr(ADR_CODE0, c[31:0]);
		wr(ADR_CODE1, c[63:32]);
		wr(ADR_CODE2, c[95:64]);
		wr(ADR_CLEN, {28'h0, n});
	endtask : stage
	task automatic pulse;
		@(posedge clk);
		cpt <= 1'b1;
		@(posedge clk);
		cpt <= 1'b0;
		#1;
	endtask : pulse

	task automatic t_remote;
		chk("power_up", PWR, st);
		chk("show", PWR, st);
		wr(ADR_CFG, 32'hffffffff);
		wr(ADR_CALCNT, 32'h00007fff);
		rd(ADR_CFG, CFG0, "cfg");
		rd(ADR_CALCNT, 32'h0, "calcnt");
		rd(8'h3c, 32'h0, "unmapped");
	endtask : t_remote
	task automatic t_keypad;
		for (int b = 0; b < 6; b++) begin
			key(KP_BAUD, 8'(b), 48'h0, 1'b1);
			chk("baud", b, baud);
		end
		key(KP_BAUD, 8'h6, 48'h0, 1'b0);
		chk("baud_keep", BAUD_9600, baud);
		key(KP_NONE, 8'h0, 48'h0, 1'b0);
		key(KP_PARITY, 8'h3, 48'h0, 1'b0);
		for (int p = 0; p < 3; p++) begin
			key(KP_PARITY, 8'(p), 48'h0, 1'b1);
			chk("dbits", (p == 0) ? 8 : 7, dbits);
		end
		key(KP_PORT, 8'h1, 48'h0, 1'b1);
		chk("port", 4'b0100, {gpib, ser, sh_a, sh_s});
		key(KP_ADDR, 8'h1f, 48'h0, 1'b1);
		chk("addr", 32'h1f, baddr);
		chk("nv_write", 1, nvw);
		chk("nv_image", 32'h1f, nv_out.addr);
		@(posedge clk);
		loc <= 1'b1;
		#1 chk("talk", 1, talk);
		@(posedge clk);
		loc <= 1'b0;
		#1 chk("talk_off", 0, talk);
		chk("nv_idle", 0, nvw);
	endtask : t_keypad
	task automatic t_lang;
		wr(ADR_LANG, 32'h1);
		chk("lang_ser", LANG_SCPI, lang);
		rd(ADR_STAT, 32'h3, "stat_err");
		wr(ADR_STAT, 32'h2);
		key(KP_LANG, 8'h2, 48'h0, 1'b0);
		key(KP_PORT, 8'h0, 48'h0, 1'b1);
		for (int l = 1; l < 4; l++) begin
			wr(ADR_LANG, l % 3);
			chk("lang", l % 3, lang);
		end
		rd(ADR_STAT, 32'h1, "stat_ok");
		rd(ADR_LANG, 32'h0, "lang_rd");
		wr(ADR_LANG, 32'h3);
		chk("lang_bad", LANG_SCPI, lang);
		rd(ADR_STAT, 32'h3, "stat_bad");
	endtask : t_lang
	task automatic t_lock;
		pulse;
		chk("cnt_locked", 0, cnt);
		stage(FACTORY_CODE ^ 96'h1, FACTORY_LEN);
		wr(ADR_LOCK, 32'h0);
		chk("bad_code", 1, lck);
		stage(FACTORY_CODE, FACTORY_LEN);
		wr(ADR_LOCK, 32'h0);
		chk("unlock", 1, menu);
		pulse;
		chk("cnt", 1, cnt);
		// a code that starts with a digit must be refused
		wr(ADR_STAT, 32'h2);
		stage(96'h4131, 4'h2);
		wr(ADR_NEWCODE, 32'h0);
		rd(ADR_STAT, 32'h2, "fmt_err");
		stage(96'h3141, 4'h2);
		wr(ADR_NEWCODE, 32'h0);
		wr(ADR_LOCK, 32'h1);
		chk("new_lock", 1, lck);
		key(KP_SECURE, 8'h0, 48'h363534333231, 1'b0);
		wr(ADR_LOCK, 32'h0);
		chk("new_unlock", 0, lck);
		key(KP_NEWCODE, 8'h0, 48'h313233343536, 1'b1);
		stage(96'h3132_3334_3536_515a, 4'(KEY_LEN));
		wr(ADR_LOCK, 32'h1);
		chk("kp_code", 1, lck);
		key(KP_SECURE, 8'h0, 48'h313233343536, 1'b1);
		chk("kp_unlock", 0, lck);
		key(KP_SECURE, 8'h1, 48'h313233343536, 1'b1);
		stage(96'h42, 4'h1);
		wr(ADR_NEWCODE, 32'h0);
		wr(ADR_LOCK, 32'h0);
		chk("locked_chg", 1, lck);
		@(posedge clk);
		jmp <= 1'b1;
		wr(ADR_NEWCODE, 32'h0);
		@(posedge clk);
		jmp <= 1'b0;
		wr(ADR_LOCK, 32'h0);
		chk("jumper", 0, lck);
	endtask : t_lock
	task automatic t_nv;
		img = NV_FACTORY;
		img.port = PORT_SERIAL;
		reset_dut(img);
		chk("pwr_ser", PWR ^ 17'h18003, st);
		img.locked = 1'b0;
		img.cal_count = 15'h7ffe;
		reset_dut(img);
		pulse;
		chk("cnt_max", 32'h7fff, cnt);
		pulse;
		chk("cnt_wrap", 0, cnt);
		@(posedge clk);
		fac <= 1'b1;
		@(posedge clk);
		fac <= 1'b0;
		#1 chk("factory", 1, lck);
		stage(FACTORY_CODE, FACTORY_LEN);
		wr(ADR_LOCK, 32'h0);
		chk("fac_code", 0, lck);
	endtask : t_nv

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up

	initial begin
		repeat (5000) @(posedge clk);
		fail_count++;
		wrap_up;
	end
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		{fac, jmp, loc, cpt} = 4'h0;
		kp = '0;
		nv_in = NV_FACTORY;
		reset_dut(NV_FACTORY);
		t_remote;
		t_keypad;
		t_lang;
		t_lock;
		t_nv;
		wrap_up;
	end
endmodule : icl_cfg_lock_tb
